/* File: logic/gpc_pkg.sv */
package gpc_pkg;
   // register indices; byte address is four times the index
   localparam logic [15:0] IDX_P2_DIR   = 16'hFF22;
   localparam logic [15:0] IDX_P3_DIR   = 16'hFF23;
   localparam logic [15:0] IDX_P12_DIR  = 16'hFF2C;
   localparam logic [15:0] IDX_RST_FN   = 16'hFF2D;
   localparam logic [15:0] IDX_P3_PU    = 16'hFF33;
   localparam logic [15:0] IDX_ALT_SW   = 16'hFF39;
   localparam logic [15:0] IDX_P12_PU   = 16'hFF3C;
   localparam logic [15:0] IDX_CLK_MODE = 16'hFF40;
   localparam logic [15:0] IDX_PIN_STAT = 16'hFF41;

   localparam logic [7:0] DIR_RST      = 8'hFF;
   localparam logic [7:0] P3_PU_RST    = 8'h00;
   localparam logic [7:0] P12_PU_RST   = 8'h20;
   localparam logic [7:0] RST_FN_RST   = 8'h00;
   localparam logic [7:0] ALT_SW_RST   = 8'h00;
   localparam logic [7:0] CLK_MODE_RST = 8'h00;

   localparam int RESET_PIN_AS_PORT_FLAG_BIT      = 5;
   localparam int RESET_PIN_PULLUP_BIT_BIT     = 5;
   localparam int IRQ1_SEL_LSB  = 6;
   localparam int TM00_SEL_LSB  = 4;
   localparam int TIMER00_CAPTURE_IN_B_SEL_BIT = 1;
   localparam int TIMER00_OUT_SEL_BIT  = 0;

   localparam logic [1:0] CLK_PORT     = 2'h0;
   localparam logic [1:0] CLK_RESON    = 2'h1;
   localparam logic [1:0] CLK_EXTERNAL = 2'h2;

   localparam logic [1:0] SEL_DEFAULT = 2'h0;
   localparam logic [1:0] SEL_CRYSTAL_IN_SHARED_PIN    = 2'h1;
   localparam logic [1:0] SEL_RESET_SHARED_PIN    = 2'h2;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: logic/gpc_pin_cell.sv */
`timescale 1ns/1ps
// one pad: output buffer, pull-up gate and input sample
module gpc_pin_cell (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic dir_in,
   input  wire logic pull_sel,
   input  wire logic alt_out_en,
   input  wire logic out_data,
   input  wire logic force_in,
   input  wire logic pin_i,
   output logic      pin_o,
   output logic      pin_oe_n,
   output logic      pullup_en,
   output logic      level
);
   typedef struct packed {
      logic o;
      logic oe_n;
      logic pu;
      logic lvl;
   } gpc_cell_t;

   gpc_cell_t s_reg;
   gpc_cell_t s_next;
   logic      drive;

   always_comb begin
      s_next = s_reg;
      drive = !force_in && (!dir_in || alt_out_en);
      s_next.o = out_data;
      s_next.oe_n = !drive;
      // pull-up never fights a driven pad
      s_next.pu = pull_sel && !drive;
      s_next.lvl = pin_i;
      if (!aresetn) begin
         // level keeps tracking the pad so no false low follows reset
         s_next = '{o: 1'b0, oe_n: 1'b1, pu: 1'b0, lvl: pin_i};
      end
   end

   always_ff @(posedge aclk) begin
      s_reg <= s_next;
   end

   assign pin_o     = s_reg.o;
   assign pin_oe_n  = s_reg.oe_n;
   assign pullup_en = s_reg.pu;
   assign level     = s_reg.lvl;
endmodule

/* File: logic/gpc_port_ctrl.sv */
`timescale 1ns/1ps
module gpc_port_ctrl #(
   parameter bit SIXTEEN_PIN = 1'b1,
   parameter int ADDR_W      = 18
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]        s_axi_awprot,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]        s_axi_arprot,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic [7:0]        port2_pin_i,
   output logic [7:0]             port2_pin_o,
   output logic [7:0]             port2_pin_oe_n,
   input  wire logic [7:0]        port2_latch,
   input  wire logic [4:0]        port3_pin_i,
   output logic [4:0]             port3_pin_o,
   output logic [4:0]             port3_pin_oe_n,
   output logic [4:0]             port3_pullup_en,
   input  wire logic [4:0]        port3_latch,
   input  wire logic [2:0]        port12_pin_i,
   output logic [2:0]             port12_pin_o,
   output logic [2:0]             port12_pin_oe_n,
   output logic [2:0]             port12_pullup_en,
   input  wire logic [1:0]        port12_latch,
   input  wire logic              serial_tx_line,
   input  wire logic              serial_tx_en,
   input  wire logic              timer_h1_out,
   input  wire logic              timer_h1_en,
   input  wire logic              timer00_out,
   input  wire logic              timer00_en,
   input  wire logic              comparator_out,
   input  wire logic              comparator_en,
   output logic                   ext_irq0_in,
   output logic                   ext_irq1_in,
   output logic                   timer00_capture_in_a,
   output logic                   timer00_capture_in_b,
   output logic                   timer51_in,
   output logic                   serial_rx_line,
   output logic                   debug_tool_clock,
   output logic                   debug_tool_data,
   output logic                   resonator_en,
   output logic                   external_clock_en,
   output logic                   chip_reset_hold
);
   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        aw_ok;
      logic        w_ok;
      logic [15:0] aw_idx;
      logic [7:0]  wbyte;
      logic        wlane;
      logic        arready;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
      logic [7:0]  p2_dir;
      logic [7:0]  p3_dir;
      logic [7:0]  p12_dir;
      logic [7:0]  p3_pu;
      logic [7:0]  p12_pu;
      logic [7:0]  rst_fn;
      logic [7:0]  alt_sw;
      logic [7:0]  clk_mode;
      logic        irq0;
      logic        irq1;
      logic        cap_a;
      logic        cap_b;
      logic        t51;
      logic        rx;
      logic        dbg_clk;
      logic        dbg_data;
      logic        res_en;
      logic        ext_en;
      logic        rst_hold;
   } gpc_state_t;

   gpc_state_t s_reg;
   gpc_state_t s_next;

   logic [7:0] p2_lvl;
   logic [4:0] p3_lvl;
   logic [2:0] p12_lvl;
   logic [4:0] p3_alt_en;
   logic [4:0] p3_alt_d;
   logic [2:0] p12_dir_in;
   logic [2:0] p12_force;
   logic [2:0] p12_pull;
   logic [2:0] p12_data;
   logic       osc_owns;
   logic [1:0] irq1_sel;
   logic [1:0] tm00_sel;
   logic       timer00_capture_in_b_sel;
   logic       timer00_out_sel;

   // rerouting exists only on the 16-pin variant
   assign irq1_sel  = SIXTEEN_PIN ?
      s_reg.alt_sw[gpc_pkg::IRQ1_SEL_LSB +: 2] : gpc_pkg::SEL_DEFAULT;
   assign tm00_sel  = SIXTEEN_PIN ?
      s_reg.alt_sw[gpc_pkg::TM00_SEL_LSB +: 2] : gpc_pkg::SEL_DEFAULT;
   assign timer00_capture_in_b_sel = SIXTEEN_PIN &&
      s_reg.alt_sw[gpc_pkg::TIMER00_CAPTURE_IN_B_SEL_BIT];
   assign timer00_out_sel  = SIXTEEN_PIN &&
      s_reg.alt_sw[gpc_pkg::TIMER00_OUT_SEL_BIT];

   // port 3 alternate outputs override the latch
   always_comb begin
      p3_alt_en = 5'h00;
      p3_alt_d  = port3_latch;
      p3_alt_en[0] = timer_h1_en;
      p3_alt_d[0]  = timer_h1_en ? timer_h1_out : port3_latch[0];
      p3_alt_en[1] = serial_tx_en || (timer00_out_sel && timer00_en);
      if (serial_tx_en) begin
         p3_alt_d[1] = serial_tx_line;
      end else if (timer00_out_sel && timer00_en) begin
         p3_alt_d[1] = timer00_out;
      end
      p3_alt_en[4] = comparator_en || (!timer00_out_sel && timer00_en);
      if (comparator_en) begin
         p3_alt_d[4] = comparator_out;
      end else if (!timer00_out_sel && timer00_en) begin
         p3_alt_d[4] = timer00_out;
      end
   end

   // clock modes other than port hand the crystal pins to the oscillator
   assign osc_owns   = s_reg.clk_mode[1:0] != gpc_pkg::CLK_PORT;
   assign p12_dir_in = {1'b1, s_reg.p12_dir[2], s_reg.p12_dir[1]};
   assign p12_force  = {1'b1, osc_owns, osc_owns};
   assign p12_pull   = {s_reg.p12_pu[gpc_pkg::RESET_PIN_PULLUP_BIT_BIT],
                        s_reg.p12_pu[2] && !osc_owns,
                        s_reg.p12_pu[1] && !osc_owns};
   assign p12_data   = {1'b0, port12_latch};

   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_p2
         gpc_pin_cell u_cell (
            .aclk       (aclk),
            .aresetn    (aresetn),
            .dir_in     (s_reg.p2_dir[g]),
            .pull_sel   (1'b0),
            .alt_out_en (1'b0),
            .out_data   (port2_latch[g]),
            .force_in   (1'b0),
            .pin_i      (port2_pin_i[g]),
            .pin_o      (port2_pin_o[g]),
            .pin_oe_n   (port2_pin_oe_n[g]),
            .pullup_en  (),
            .level      (p2_lvl[g])
         );
      end
      for (g = 0; g < 5; g++) begin : g_p3
         gpc_pin_cell u_cell (
            .aclk       (aclk),
            .aresetn    (aresetn),
            .dir_in     (s_reg.p3_dir[g]),
            .pull_sel   (s_reg.p3_pu[g]),
            .alt_out_en (p3_alt_en[g]),
            .out_data   (p3_alt_d[g]),
            .force_in   (1'b0),
            .pin_i      (port3_pin_i[g]),
            .pin_o      (port3_pin_o[g]),
            .pin_oe_n   (port3_pin_oe_n[g]),
            .pullup_en  (port3_pullup_en[g]),
            .level      (p3_lvl[g])
         );
      end
      for (g = 0; g < 3; g++) begin : g_p12
         gpc_pin_cell u_cell (
            .aclk       (aclk),
            .aresetn    (aresetn),
            .dir_in     (p12_dir_in[g]),
            .pull_sel   (p12_pull[g]),
            .alt_out_en (1'b0),
            .out_data   (p12_data[g]),
            .force_in   (p12_force[g]),
            .pin_i      (port12_pin_i[g]),
            .pin_o      (port12_pin_o[g]),
            .pin_oe_n   (port12_pin_oe_n[g]),
            .pullup_en  (port12_pullup_en[g]),
            .level      (p12_lvl[g])
         );
      end
   endgenerate

   always_comb begin
      logic [15:0] ridx;
      logic [31:0] rd;
      logic        hit;
      ridx = s_axi_araddr[17:2];
      rd = 32'h0000_0000;
      hit = 1'b1;
      s_next = s_reg;

      // write channel: address and data taken in either order
      if (s_reg.bvalid && s_axi_bready) begin
         s_next.bvalid = 1'b0;
      end
      if (s_axi_awvalid && s_reg.awready) begin
         s_next.aw_ok = 1'b1;
         s_next.aw_idx = s_axi_awaddr[17:2];
      end
      if (s_axi_wvalid && s_reg.wready) begin
         s_next.w_ok = 1'b1;
         s_next.wbyte = s_axi_wdata[7:0];
         s_next.wlane = s_axi_wstrb[0];
      end
      if (s_reg.aw_ok && s_reg.w_ok && !s_reg.bvalid) begin
         s_next.aw_ok = 1'b0;
         s_next.w_ok = 1'b0;
         s_next.bvalid = 1'b1;
         s_next.bresp = gpc_pkg::RESP_OKAY;
         case (s_reg.aw_idx)
            gpc_pkg::IDX_P2_DIR: begin
               if (s_reg.wlane) s_next.p2_dir = s_reg.wbyte;
            end
            gpc_pkg::IDX_P3_DIR: begin
               if (s_reg.wlane) s_next.p3_dir = s_reg.wbyte;
            end
            gpc_pkg::IDX_P12_DIR: begin
               if (s_reg.wlane) s_next.p12_dir = s_reg.wbyte;
            end
            gpc_pkg::IDX_P3_PU: begin
               if (s_reg.wlane) s_next.p3_pu = s_reg.wbyte;
            end
            gpc_pkg::IDX_P12_PU: begin
               if (s_reg.wlane) s_next.p12_pu = s_reg.wbyte;
            end
            gpc_pkg::IDX_RST_FN: begin
               if (s_reg.wlane) s_next.rst_fn = s_reg.wbyte;
            end
            gpc_pkg::IDX_ALT_SW: begin
               if (s_reg.wlane) s_next.alt_sw = s_reg.wbyte;
            end
            gpc_pkg::IDX_CLK_MODE: begin
               if (s_reg.wlane) s_next.clk_mode = s_reg.wbyte;
            end
            gpc_pkg::IDX_PIN_STAT: begin
            end
            default: s_next.bresp = gpc_pkg::RESP_SLVERR;
         endcase
      end
      s_next.awready = !s_next.aw_ok && !s_next.bvalid;
      s_next.wready  = !s_next.w_ok && !s_next.bvalid;

      // read channel: one read at a time, data straight from registers
      case (ridx)
         gpc_pkg::IDX_P2_DIR:   rd[7:0] = s_reg.p2_dir;
         gpc_pkg::IDX_P3_DIR:   rd[7:0] = s_reg.p3_dir;
         gpc_pkg::IDX_P12_DIR:  rd[7:0] = s_reg.p12_dir;
         gpc_pkg::IDX_P3_PU:    rd[7:0] = s_reg.p3_pu;
         gpc_pkg::IDX_P12_PU:   rd[7:0] = s_reg.p12_pu;
         gpc_pkg::IDX_RST_FN:   rd[7:0] = s_reg.rst_fn;
         gpc_pkg::IDX_ALT_SW:   rd[7:0] = s_reg.alt_sw;
         gpc_pkg::IDX_CLK_MODE: rd[7:0] = s_reg.clk_mode;
         gpc_pkg::IDX_PIN_STAT: begin
            rd = {8'h00, p2_lvl, 7'h00, s_reg.rst_hold,
                  p12_lvl, p3_lvl};
         end
         default: hit = 1'b0;
      endcase
      if (s_reg.rvalid && s_axi_rready) begin
         s_next.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_reg.arready) begin
         s_next.rvalid = 1'b1;
         s_next.rdata = rd;
         s_next.rresp = hit ? gpc_pkg::RESP_OKAY : gpc_pkg::RESP_SLVERR;
      end
      s_next.arready = !s_next.rvalid;

      // shared input functions, sampled once more so outputs are flops
      s_next.irq0 = p3_lvl[0];
      s_next.t51  = p3_lvl[0];
      s_next.rx   = p3_lvl[2];
      case (irq1_sel)
         gpc_pkg::SEL_CRYSTAL_IN_SHARED_PIN: s_next.irq1 = p12_lvl[0];
         gpc_pkg::SEL_RESET_SHARED_PIN: s_next.irq1 = p12_lvl[2];
         default:           s_next.irq1 = p3_lvl[3];
      endcase
      case (tm00_sel)
         gpc_pkg::SEL_CRYSTAL_IN_SHARED_PIN: s_next.cap_a = p12_lvl[0];
         gpc_pkg::SEL_RESET_SHARED_PIN: s_next.cap_a = p12_lvl[2];
         default:           s_next.cap_a = p3_lvl[3];
      endcase
      s_next.cap_b = timer00_capture_in_b_sel ? p3_lvl[2] : p3_lvl[4];
      s_next.dbg_clk  = p12_lvl[0];
      s_next.dbg_data = p12_lvl[1];
      s_next.res_en = s_reg.clk_mode[1:0] == gpc_pkg::CLK_RESON;
      s_next.ext_en = s_reg.clk_mode[1:0] == gpc_pkg::CLK_EXTERNAL;
      // while rst_fn bit 5 is clear, a low reset pin keeps the chip held until it rises
      s_next.rst_hold = !s_reg.rst_fn[gpc_pkg::RESET_PIN_AS_PORT_FLAG_BIT] &&
                        !p12_lvl[2];

      if (!aresetn) begin
         s_next = '0;
         s_next.p2_dir   = gpc_pkg::DIR_RST;
         s_next.p3_dir   = gpc_pkg::DIR_RST;
         s_next.p12_dir  = gpc_pkg::DIR_RST;
         s_next.p3_pu    = gpc_pkg::P3_PU_RST;
         s_next.p12_pu   = gpc_pkg::P12_PU_RST;
         s_next.rst_fn   = gpc_pkg::RST_FN_RST;
         s_next.alt_sw   = gpc_pkg::ALT_SW_RST;
         s_next.clk_mode = gpc_pkg::CLK_MODE_RST;
      end
   end

   always_ff @(posedge aclk) begin
      s_reg <= s_next;
   end

   assign s_axi_awready        = s_reg.awready;
   assign s_axi_wready         = s_reg.wready;
   assign s_axi_bvalid         = s_reg.bvalid;
   assign s_axi_bresp          = s_reg.bresp;
   assign s_axi_arready        = s_reg.arready;
   assign s_axi_rvalid         = s_reg.rvalid;
   assign s_axi_rdata          = s_reg.rdata;
   assign s_axi_rresp          = s_reg.rresp;
   assign ext_irq0_in          = s_reg.irq0;
   assign ext_irq1_in          = s_reg.irq1;
   assign timer00_capture_in_a = s_reg.cap_a;
   assign timer00_capture_in_b = s_reg.cap_b;
   assign timer51_in           = s_reg.t51;
   assign serial_rx_line       = s_reg.rx;
   assign debug_tool_clock     = s_reg.dbg_clk;
   assign debug_tool_data      = s_reg.dbg_data;
   assign resonator_en         = s_reg.res_en;
   assign external_clock_en    = s_reg.ext_en;
   assign chip_reset_hold      = s_reg.rst_hold;
endmodule

/* File: dv/gpc_port_properties.sv */
`timescale 1ns/1ps
module gpc_port_checker (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [4:0]  port3_pin_i,
   input wire logic [4:0]  port3_pin_oe_n,
   input wire logic [4:0]  port3_pullup_en,
   input wire logic [2:0]  port12_pin_i,
   input wire logic [2:0]  port12_pin_oe_n,
   input wire logic [2:0]  port12_pullup_en,
   input wire logic        serial_rx_line,
   input wire logic        chip_reset_hold
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   write_answer_a: assert property (wr_taken |-> ##2 s_axi_bvalid)
      else $error("write response late");
   read_answer_a: assert property (rd_taken |=> s_axi_rvalid)
      else $error("read data late");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
   reset_inputs_a: assert property ($rose(aresetn) |->
      port3_pin_oe_n == 5'h1F && port12_pin_oe_n == 3'h7)
      else $error("pad driven out of reset");
   reset_pullup_a: assert property ($rose(aresetn)
      |-> ##[1:2] port12_pullup_en[2]) else $error("reset pin pull-up off");
   reset_pin_input_a: assert property (port12_pin_oe_n[2])
      else $error("reset pin driven");
   pullup_driven_a: assert property (
      (port3_pullup_en & ~port3_pin_oe_n) == 5'h00 &&
      (port12_pullup_en & ~port12_pin_oe_n) == 3'h0)
      else $error("pull-up on driven pad");
   reset_hold_a: assert property (chip_reset_hold
      |-> $past(port12_pin_i[2], 2) == 1'h0) else $error("hold without low");
   rx_follow_a: assert property ($past(aresetn, 3) &&
      $past(aresetn, 2) && $past(aresetn)
      |-> serial_rx_line == $past(port3_pin_i[2], 2))
      else $error("rx line not following pad");
endmodule

/* File: dv/gpc_board.sv */
`timescale 1ns/1ps
// board wiring: chip drive wins, then board driver, then pull-up;
// an undriven pad without pull-up toggles every cycle so no stale level survives
module gpc_board #(
   parameter int W = 1
) (
   input  wire logic         aclk,
   input  wire logic [W-1:0] pin_o,
   input  wire logic [W-1:0] oe_n,
   input  wire logic [W-1:0] pull_en,
   input  wire logic [W-1:0] drv_en,
   input  wire logic [W-1:0] drv_val,
   output logic      [W-1:0] pin_i
);
   logic [W-1:0] flt = '0;
   always_ff @(posedge aclk) begin
      flt <= ~flt;
   end
   assign pin_i = (~oe_n & pin_o) | (oe_n & drv_en & drv_val)
                | (oe_n & ~drv_en & (pull_en | flt));
endmodule

/* File: dv/gpc_port_ctrl_bench.sv */
`timescale 1ns/1ps
module gpc_port_ctrl_bench;
   logic        aclk, aresetn;
   logic [17:0] s_axi_awaddr, s_axi_araddr;
   logic [2:0]  s_axi_awprot, s_axi_arprot;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic [7:0]  port2_pin_i, port2_pin_o, port2_pin_oe_n, port2_latch;
   logic [7:0]  p2_den, p2_dv;
   logic [4:0]  port3_pin_i, port3_pin_o, port3_pin_oe_n, port3_latch;
   logic [4:0]  port3_pullup_en, p3_den, p3_dv;
   logic [2:0]  port12_pin_i, port12_pin_o, port12_pin_oe_n;
   logic [2:0]  port12_pullup_en, p12_den, p12_dv;
   logic [1:0]  port12_latch;
   logic        serial_tx_line, serial_tx_en, timer_h1_out, timer_h1_en;
   logic        timer00_out, timer00_en, comparator_out, comparator_en;
   logic        ext_irq0_in, ext_irq1_in, timer00_capture_in_a;
   logic        timer00_capture_in_b, timer51_in, serial_rx_line;
   logic        debug_tool_clock, debug_tool_data, resonator_en;
   logic        external_clock_en, chip_reset_hold;
   int          failures, n_tests;
   localparam logic [15:0] RIDX [8] = '{gpc_pkg::IDX_P2_DIR,
      gpc_pkg::IDX_P3_DIR, gpc_pkg::IDX_P12_DIR, gpc_pkg::IDX_RST_FN,
      gpc_pkg::IDX_P3_PU, gpc_pkg::IDX_ALT_SW, gpc_pkg::IDX_P12_PU,
      gpc_pkg::IDX_CLK_MODE};
   localparam logic [7:0] RRST [8] = '{8'hFF, 8'hFF, 8'hFF, 8'h00,
      8'h00, 8'h00, 8'h20, 8'h00};
   localparam logic [1:0] CM [3] = '{2'h1, 2'h2, 2'h0};
   localparam logic [1:0] CME [3] = '{2'h2, 2'h1, 2'h0};
   localparam logic [7:0] AS [3] = '{8'h00, 8'h52, 8'hA2};
   localparam logic AE [3] = '{1'h1, 1'h1, 1'h0};
   localparam logic BE [3] = '{1'h0, 1'h1, 1'h1};
   localparam logic [1:0] OK = gpc_pkg::RESP_OKAY;

   gpc_port_ctrl dut (.*);
   gpc_board #(.W(8)) brd2 (.aclk(aclk), .pin_o(port2_pin_o),
      .oe_n(port2_pin_oe_n), .pull_en(8'h00), .drv_en(p2_den),
      .drv_val(p2_dv), .pin_i(port2_pin_i));
   gpc_board #(.W(5)) brd3 (.aclk(aclk), .pin_o(port3_pin_o),
      .oe_n(port3_pin_oe_n), .pull_en(port3_pullup_en), .drv_en(p3_den),
      .drv_val(p3_dv), .pin_i(port3_pin_i));
   gpc_board #(.W(3)) brd12 (.aclk(aclk), .pin_o(port12_pin_o),
      .oe_n(port12_pin_oe_n), .pull_en(port12_pullup_en),
      .drv_en(p12_den), .drv_val(p12_dv), .pin_i(port12_pin_i));

   task automatic chk(input string nm, input logic [31:0] seen,
                      input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic timeout;
      failures++;
      print_verdict;
   endtask

   // pads move one edge after the register; sample off the edge
   task automatic settle;
      repeat (3) @(posedge aclk);
      @(negedge aclk);
   endtask

   task automatic wr(input logic [15:0] idx, input logic [7:0] d,
                     input logic [1:0] er);
      logic ta, tw, tb;
      logic [1:0] rs;
      int n;
      @(posedge aclk);
      s_axi_awaddr <= {idx, 2'h0};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      for (n = 0; n < 40; n++) begin
         @(negedge aclk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tb = s_axi_bvalid && s_axi_bready;
         rs = s_axi_bresp;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'h0;
         if (tw) s_axi_wvalid <= 1'h0;
         if (tb) break;
      end
      s_axi_bready <= 1'h0;
      if (n == 40) timeout;
      chk("bresp", rs, er);
   endtask

   task automatic rd(input logic [15:0] idx, input logic [31:0] exp,
                     input logic [1:0] er);
      logic ta, tr;
      logic [31:0] d;
      logic [1:0] rs;
      int n;
      @(posedge aclk);
      s_axi_araddr <= {idx, 2'h0};
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      for (n = 0; n < 40; n++) begin
         @(negedge aclk);
         ta = s_axi_arvalid && s_axi_arready;
         tr = s_axi_rvalid && s_axi_rready;
         d = s_axi_rdata;
         rs = s_axi_rresp;
         @(posedge aclk);
         if (ta) s_axi_arvalid <= 1'h0;
         if (tr) break;
      end
      s_axi_rready <= 1'h0;
      if (n == 40) timeout;
      chk("rdata", d, exp);
      chk("rresp", rs, er);
   endtask

   initial begin
      aclk = 1'h0;
      forever #5 aclk = ~aclk;
   end

   initial begin
      {failures, n_tests} = '0;
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, s_axi_awprot, s_axi_arprot} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {serial_tx_line, serial_tx_en, timer_h1_out, timer_h1_en} = '0;
      {timer00_out, timer00_en, comparator_out, comparator_en} = '0;
      s_axi_wstrb = 4'hF;
      port2_latch = 8'hA5;
      port3_latch = 5'h15;
      port12_latch = 2'h2;
      {p3_den, p3_dv, p2_den, p2_dv} = '0;
      // external reset line released high by the board
      {p12_den, p12_dv} = {3'h4, 3'h4};
      repeat (5) @(posedge aclk);
      aresetn <= 1'h1;
      for (int i = 0; i < 8; i++) rd(RIDX[i], {24'h0, RRST[i]}, OK);
      settle;
      chk("p3 oe_n", port3_pin_oe_n, 5'h1F);
      chk("p12 oe_n", port12_pin_oe_n, 3'h7);
      chk("rst pull", port12_pullup_en[2], 1'h1);
      $display("test reset values done");

      @(posedge aclk);
      p12_dv <= 3'h0;
      settle;
      chk("hold low", chip_reset_hold, 1'h1);
      @(posedge aclk);
      p12_dv <= 3'h4;
      settle;
      chk("hold high", chip_reset_hold, 1'h0);
      wr(gpc_pkg::IDX_RST_FN, 8'h20, OK);
      @(posedge aclk);
      p12_dv <= 3'h0;
      settle;
      chk("port mode", chip_reset_hold, 1'h0);
      $display("test reset pin done");

      wr(gpc_pkg::IDX_P3_PU, 8'h1F, OK);
      wr(gpc_pkg::IDX_P3_DIR, 8'hFA, OK);
      settle;
      chk("p3 dir", port3_pin_oe_n, 5'h1A);
      chk("p3 out", {port3_pin_o[2], port3_pin_o[0]}, 2'h3);
      chk("p3 pull", port3_pullup_en, 5'h1A);
      rd(gpc_pkg::IDX_P3_DIR, 32'h0000_00FA, OK);
      wr(gpc_pkg::IDX_ALT_SW, 8'h01, OK);
      @(posedge aclk);
      {timer00_en, timer00_out, comparator_en} <= 3'h7;
      settle;
      chk("alt oe_n", port3_pin_oe_n, 5'h08);
      chk("alt pull", port3_pullup_en, 5'h08);
      chk("alt out", {port3_pin_o[4], port3_pin_o[1]}, 2'h1);
      @(posedge aclk);
      {timer00_en, timer00_out, comparator_en} <= 3'h0;
      $display("test port3 done");

      wr(gpc_pkg::IDX_P12_DIR, 8'hF9, OK);
      settle;
      chk("p12 dir", port12_pin_oe_n, 3'h4);
      chk("p12 out", port12_pin_o[1:0], port12_latch);
      for (int i = 0; i < 3; i++) begin
         wr(gpc_pkg::IDX_CLK_MODE, {6'h0, CM[i]}, OK);
         settle;
         chk("clk en", {resonator_en, external_clock_en}, CME[i]);
         chk("xtal oe", port12_pin_oe_n[1:0],
             (CM[i] == 2'h0) ? 2'h0 : 2'h3);
      end
      wr(gpc_pkg::IDX_P12_DIR, 8'hFF, OK);
      $display("test port12 done");

      wr(gpc_pkg::IDX_P2_DIR, 8'hD8, OK);
      settle;
      chk("p2 dir", port2_pin_oe_n, 8'hD8);
      chk("p2 out", port2_pin_o, port2_latch);
      $display("test port2 done");

      @(posedge aclk);
      {p12_den, p12_dv} <= {3'h7, 3'h1};
      {p3_den, p3_dv} <= {5'h18, 5'h08};
      {p2_den, p2_dv} <= {8'hFF, 8'h3C};
      for (int i = 0; i < 3; i++) begin
         wr(gpc_pkg::IDX_ALT_SW, AS[i], OK);
         settle;
         chk("irq1 route", ext_irq1_in, AE[i]);
         chk("cap a route", timer00_capture_in_a, AE[i]);
         chk("cap b route", timer00_capture_in_b, BE[i]);
      end
      chk("shared in", {ext_irq0_in, timer51_in,
          debug_tool_clock, debug_tool_data}, 4'hE);
      rd(gpc_pkg::IDX_PIN_STAT, 32'h003D_002F, OK);
      $display("test alt switch done");

      rd(16'hFF30, 32'h0, gpc_pkg::RESP_SLVERR);
      wr(16'hFF30, 8'h00, gpc_pkg::RESP_SLVERR);
      $display("test unmapped done");

      // reset pin still held low by the board across this reset
      @(posedge aclk);
      aresetn <= 1'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      settle;
      chk("p2 oe_n rst", port2_pin_oe_n, 8'hFF);
      chk("p3 oe_n rst", port3_pin_oe_n, 5'h1F);
      chk("hold rst", chip_reset_hold, 1'h1);
      $display("test second reset done");
      print_verdict;
   end
endmodule

bind gpc_port_ctrl gpc_port_checker chk_i (.*);
